// file: src/anar_defs.vh
`ifndef ANAR_DEFS_VH
`define ANAR_DEFS_VH
// register address on the management interface
`define ANAR_ADDR 5'h04
// field positions
`define ANAR_NEXT_PAGE 15
`define ANAR_ACK_RSVD 14
`define ANAR_REMOTE_FAULT 13
`define ANAR_RSVD_HI 12
`define ANAR_RSVD_LO 10
`define ANAR_T4 9
`define ANAR_TAF_HI 8
`define ANAR_TAF_LO 5
`define ANAR_SEL_HI 4
`define ANAR_SEL_LO 0
// reset values
`define ANAR_SEL_DEFAULT 5'h01
`define ANAR_TAF_AN_DEFAULT 4'hF
`define ANAR_TAF_FORCED_DEFAULT 4'h0
`define ANAR_RESET_VALUE 16'h01E1
`endif

// file: src/anar_field.v
`default_nettype none
// one storage field with reset value and optional write guard
module anar_field #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clock,
  input wire srst,
  // load control
  input wire load_default,
  input wire [WIDTH-1:0] default_value,
  input wire write_en,
  input wire [WIDTH-1:0] write_value,
  // stored value
  output reg [WIDTH-1:0] value
);
  always @(posedge clock) begin
    if (srst || load_default) begin
      value <= default_value;
    end else if (write_en) begin
      value <= write_value;
    end
  end
endmodule
`default_nettype wire

// file: src/anar_fault.v
`default_nettype none
// remote fault flag tracks the local link fault detector
module anar_fault (
  // clock and reset
  input wire clock,
  input wire srst,
  // local fault level
  input wire link_fault,
  // flag
  output reg remote_fault
);
  always @(posedge clock) begin
    if (srst) begin
      remote_fault <= 1'b0;
    end else begin
      remote_fault <= link_fault;
    end
  end
endmodule
`default_nettype wire

// file: src/anar_top.v
// Function
// R1: next page bit read/write, resets 0, advertised to partner as is
// R2: reserved bits 14 and 12:10 always read zero
// R3: override-write bits accept writes only while override bit is 1
// R4: manager writes reserved bits as zero on every write
// R5: remote fault set on local link problem, cleared otherwise, resets 0
// R6: with autoneg on, remote fault goes out in the link code word
// R7: link code word built from register, valid while autoneg enabled
// R8: ability bits 8..5 advertise TX-FD, TX-HD, 10-FD, 10-HD; set with autoneg
// R9: ability bit 1 means supported, 0 means not supported
// R10: bit 9 always reads 0, no 100BASE-T4
// R11: ability defaults follow mode pin and autoneg enable
// R12: autoneg off: idle, speed and duplex from control bits
// R13: autoneg on: negotiate, advertising bits 8..5
// R14: status capability bits never follow this register
// R15: manager may rewrite abilities then restart negotiation
// R16: selector field defaults 00001, override-write
// R17: reset value 0x01E1 with autoneg enabled by default
`default_nettype none
`include "anar_defs.vh"
module anar_top (
  // clock and reset
  input wire clock,
  input wire srst,
  // management register access
  input wire [4:0] reg_addr,
  input wire reg_write,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  // control from other registers
  input wire override_write_access,
  input wire autoneg_enable,
  input wire speed_select,
  input wire duplex_select,
  input wire mode_pin_a,
  input wire autoneg_restart,
  // local link fault detector
  input wire link_fault,
  // toward the fast link pulse transmitter
  output reg [15:0] link_code_word,
  output reg link_code_valid,
  output reg forced_mode,
  output reg forced_speed_100,
  output reg forced_full_duplex,
  output reg restart_negotiation,
  // status register capabilities, fixed
  output reg [3:0] status_abilities
);
  wire wr_hit;
  wire wr_cw;
  wire wr_rw;
  wire [3:0] taf_default;
  wire [3:0] technology_ability_field;
  wire [4:0] selector;
  wire [3:0] rsvd;
  wire next_page;
  wire remote_fault;
  reg mode_seen;
  reg an_prev;
  reg load_taf;
  reg [15:0] next_image;

  assign wr_hit = reg_write && (reg_addr == `ANAR_ADDR);
  assign wr_cw = wr_hit && override_write_access; // R3
  assign wr_rw = wr_hit;
  // ability defaults: all on with autoneg or hardware mode, else off
  assign taf_default = (autoneg_enable || mode_pin_a) ?
    `ANAR_TAF_AN_DEFAULT : `ANAR_TAF_FORCED_DEFAULT; // R11 R17

  // reload defaults once after reset and when autoneg is toggled
  always @(posedge clock) begin
    if (srst) begin
      mode_seen <= 1'b0;
      an_prev <= 1'b0;
      load_taf <= 1'b0;
    end else begin
      mode_seen <= 1'b1;
      an_prev <= autoneg_enable;
      load_taf <= !mode_seen || (an_prev != autoneg_enable); // R11
    end
  end

  anar_field #(.WIDTH(1)) u_next_page (
    .clock(clock),
    .srst(srst),
    .load_default(1'b0),
    .default_value(1'b0),
    .write_en(wr_rw),
    .write_value(reg_wdata[`ANAR_NEXT_PAGE]),
    .value(next_page)
  ); // R1

  anar_field #(.WIDTH(4)) u_reserved (
    .clock(clock),
    .srst(srst),
    .load_default(1'b0),
    .default_value(4'h0),
    .write_en(wr_cw),
    .write_value({reg_wdata[`ANAR_ACK_RSVD],
                  reg_wdata[`ANAR_RSVD_HI:`ANAR_RSVD_LO]}),
    .value(rsvd)
  ); // R3

  // ability bits are writable; defaults reloaded per R11
  anar_field #(.WIDTH(4)) u_taf (
    .clock(clock),
    .srst(srst),
    .load_default(load_taf),
    .default_value(taf_default),
    .write_en(wr_rw),
    .write_value(reg_wdata[`ANAR_TAF_HI:`ANAR_TAF_LO]),
    .value(technology_ability_field)
  ); // R8

  anar_field #(.WIDTH(5)) u_selector (
    .clock(clock),
    .srst(srst),
    .load_default(1'b0),
    .default_value(`ANAR_SEL_DEFAULT),
    .write_en(wr_cw),
    .write_value(reg_wdata[`ANAR_SEL_HI:`ANAR_SEL_LO]),
    .value(selector)
  ); // R16

  anar_fault u_fault (
    .clock(clock),
    .srst(srst),
    .link_fault(link_fault),
    .remote_fault(remote_fault)
  ); // R5

  // register image as seen by the manager
  always @* begin
    next_image = 16'h0000;
    next_image[`ANAR_NEXT_PAGE] = next_page; // R1
    next_image[`ANAR_ACK_RSVD] = 1'b0; // R2
    next_image[`ANAR_REMOTE_FAULT] = remote_fault; // R5
    next_image[`ANAR_RSVD_HI:`ANAR_RSVD_LO] = 3'h0; // R2
    next_image[`ANAR_T4] = 1'b0; // R10
    next_image[`ANAR_TAF_HI:`ANAR_TAF_LO] = technology_ability_field; // R9
    next_image[`ANAR_SEL_HI:`ANAR_SEL_LO] = selector; // R16
  end

  always @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
      link_code_word <= 16'h0000;
      link_code_valid <= 1'b0;
      forced_mode <= 1'b0;
      forced_speed_100 <= 1'b0;
      forced_full_duplex <= 1'b0;
      restart_negotiation <= 1'b0;
      status_abilities <= `ANAR_TAF_AN_DEFAULT;
    end else begin
      reg_rdata <= (reg_addr == `ANAR_ADDR) ? next_image : 16'h0000;
      link_code_word <= autoneg_enable ? next_image : 16'h0000; // R6 R7 R13
      link_code_valid <= autoneg_enable; // R7 R13
      forced_mode <= !autoneg_enable; // R12
      forced_speed_100 <= !autoneg_enable && speed_select; // R12
      forced_full_duplex <= !autoneg_enable && duplex_select; // R12
      restart_negotiation <= autoneg_enable && autoneg_restart; // R15
      status_abilities <= `ANAR_TAF_AN_DEFAULT; // R14
    end
  end
endmodule
`default_nettype wire

// file: verification/anar_chk_assertions.sv
`default_nettype none
module anar_chk (
  // watched ports
  input wire logic clock, srst, autoneg_enable, autoneg_restart,
  input wire logic link_fault, link_code_valid, restart_negotiation,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_rdata, link_code_word,
  input wire logic [3:0] status_abilities
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  AST_RSVD: assert property (reg_rdata[14] == 0
    && reg_rdata[12:9] == 0) else $error("rsvd");
  AST_VALID: assert property (!$past(srst) |->
    link_code_valid == $past(autoneg_enable)) else $error("valid");
  AST_LCW_OFF: assert property (!$past(srst) && !$past(autoneg_enable)
    |-> link_code_word == 0) else $error("lcw off");
  AST_LCW_RD: assert property (!$past(srst) &&
    $past(autoneg_enable && reg_addr == 5'h04)
    |-> reg_rdata == link_code_word) else $error("lcw");
  AST_RESTART: assert property (!$past(srst) |-> restart_negotiation ==
    $past(autoneg_restart && autoneg_enable)) else $error("restart");
  AST_STATUS: assert property (status_abilities == 4'hF)
    else $error("status");
  AST_FAULT_SET: assert property ((link_fault && autoneg_enable)[*5]
    |-> link_code_word[13]) else $error("fault set");
  AST_FAULT_CLR: assert property ((!link_fault && autoneg_enable)[*5]
    |-> !link_code_word[13]) else $error("fault clr");
endmodule
bind anar_top anar_chk u_chk (.*);
`default_nettype wire

// file: verification/anar_sme.sv
`default_nettype none
module anar_sme (
  // management side
  input wire logic clock,
  input wire logic [15:0] reg_rdata,
  output logic [4:0] reg_addr,
  output logic reg_write,
  output logic [15:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 5'h00;
    reg_write = 1'h0;
    reg_wdata = 16'h0000;
  end
  task automatic wr(input logic [15:0] d);
    @(posedge clock);
    #1 reg_addr = 5'h04;
    reg_write = 1'h1;
    reg_wdata = d & 16'hA3FF;
    @(posedge clock);
    #1 reg_write = 1'h0;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] q);
    @(posedge clock);
    #1 reg_addr = a;
    @(posedge clock);
    #1 q = reg_rdata;
  endtask
endmodule
`default_nettype wire

// file: verification/test_autoneg_advertisement_register.sv
`default_nettype none
module test_autoneg_advertisement_register;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, srst = 1, override_write_access = 0, autoneg_enable = 1;
  logic speed_select = 0, duplex_select = 0, mode_pin_a = 0;
  logic autoneg_restart = 0, link_fault = 0;
  wire logic [4:0] reg_addr;
  wire logic reg_write, link_code_valid, forced_mode, forced_speed_100;
  wire logic forced_full_duplex, restart_negotiation;
  wire logic [15:0] reg_wdata, reg_rdata, link_code_word;
  wire logic [3:0] status_abilities;
  logic [15:0] d, v;
  logic [4:0] sel = 5'h01;
  int err_total = 0, comparisons = 0;
  anar_top dut (.*);
  anar_sme sme (.*);
  function automatic logic [15:0] img(input logic [15:0] w,
    input logic [4:0] s, input logic f);
    return {w[15], 1'h0, f, 4'h0, w[8:5], s};
  endfunction
  task automatic chk(input logic [4:0] a, input logic [15:0] e);
    sme.rd(a, v);
    comparisons++;
    if (v !== e) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, v, e);
    end
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop;
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    forever #5 clock = ~clock;
  end
  initial begin
    #20000;
    err_total++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h9EC8ED47));
    repeat (4) @(posedge clock);
    #1 srst = 0;
    repeat (3) @(posedge clock);
    chk(5'h04, 16'h01E1);
    chk(5'h07, 16'h0000);
    repeat (8) begin
      d = $urandom;
      override_write_access = d[0];
      if (d[0])
        sel = d[4:0];
      sme.wr(d);
      chk(5'h04, img(d, sel, 1'h0));
    end
    link_fault = 1;
    repeat (3) @(posedge clock);
    chk(5'h04, img(d, sel, 1'h1));
    autoneg_restart = 1;
    @(posedge clock);
    #1 autoneg_restart = 0;
    cmp({15'h0000, restart_negotiation}, 16'h0001);
    autoneg_enable = 0;
    speed_select = d[1];
    duplex_select = d[2];
    repeat (3) @(posedge clock);
    chk(5'h04, img(d & 16'h8000, sel, 1'h1));
    cmp({12'h000, link_code_valid, forced_mode, forced_speed_100,
      forced_full_duplex}, {12'h000, 1'h0, 1'h1, d[1], d[2]});
    cmp(link_code_word, 16'h0000);
    mode_pin_a = 1;
    autoneg_enable = 1;
    repeat (3) @(posedge clock);
    chk(5'h04, img(d | 16'h01E0, sel, 1'h1));
    cmp(link_code_word, img(d | 16'h01E0, sel, 1'h1));
    cmp({12'h000, link_code_valid, forced_mode, forced_speed_100,
      forced_full_duplex}, 16'h0008);
    report_and_stop();
  end
endmodule
`default_nettype wire
